//--- rtl/sbsram_core.sv
`timescale 1ns/10ps
`include "sbsram_defines.svh"
// How it works
// - Clock gate high freezes all state except the sleep delay counter for that edge
// - Inputs sampled on rising edge; output enable, latency mode, sleep act combinationally
// - Selected only when first low, second high, third low at load
// - Write updates only lanes whose enables are low
// - Write with no lane enabled is a no-op, bus stays High-Z
// - Read starts on selected load with write strobe high
// - Write starts on selected load with write strobe low
// - Pipeline read data appears two cycles after command
// - Flow-through read latency is one cycle
// - Continue cycles step the counter, ignoring selects and strobe
// - Burst counter is two bits stepping the low address bits
// - Deselect-continue only follows a deselect cycle
// - Read with output enable high drives nothing but still steps
// - Output drivers are off during write cycles
// - Stall keeps read data driven, write bus stays High-Z
// - Outputs High-Z from power-up until valid commands
// - Sleep entered two cycles after request, left two after release
// - Linear or interleaved order, wrap after four addresses
// - Latency mode low selects flow-through, high pipeline
module sbsram_core
   import sbsram_pkg::*;
#(
   parameter int AW = `SBS_ADDR_W,
   parameter int LANES = `SBS_LANES,
   parameter int LW = `SBS_LANE_W
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clock_gate_n,
   input wire logic select_first_n,
   input wire logic select_second,
   input wire logic select_third_n,
   input wire logic write_n,
   input wire logic [LANES-1:0] any_lane_write_n,
   input wire logic burst_step_or_load,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic latency_mode_n,
   input wire logic burst_order_select,
   input wire logic [AW-1:0] addr,
   input wire logic [LANES*LW-1:0] dq_in,
   output logic [LANES*LW-1:0] dq_out,
   output logic dq_oe,
   output logic asleep
);
   localparam int DW = LANES * LW;
   localparam int DEPTH = 1 << AW;
   localparam logic [1:0] SLEEP_CYC = 2'(`SBS_SLEEP_CYC);

   logic [DW-1:0] mem [DEPTH];
   logic hold;
   logic load_cyc;
   logic selected;
   logic [1:0] lsb;
   logic [AW-1:0] acc_addr;
   sbs_op_e op_now;
   sbs_op_e burst_op_q;
   logic [AW-1:0] base_q;
   logic [AW-1:0] a1_q;
   logic [AW-1:0] a2_q;
   sbs_op_e op1_q;
   sbs_op_e op2_q;
   logic [LANES-1:0] be1_q;
   logic [LANES-1:0] be2_q;
   logic [DW-1:0] rdata_q;
   logic rvalid_q;
   logic [1:0] sleep_cnt_q;
   logic asleep_q;
   logic flow;
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [LANES-1:0] wr_lanes_n;
   logic [DW-1:0] wr_word;

   // Refuse a geometry the address split and array cannot serve
   if (AW < 3 || AW > 20 || LANES < 1 || LW < 1)
   begin : g_bad_geometry
      $error("Unsupported core geometry");
   end

   assign flow = !latency_mode_n;
   assign hold = clock_gate_n || asleep_q;
   assign load_cyc = !burst_step_or_load;
   assign selected = !select_first_n && select_second && !select_third_n;

   // Decode this edge's operation
   always_comb
   begin
      if (!load_cyc)
         op_now = burst_op_q;
      else if (!selected)
         op_now = SBS_OP_IDLE;
      else if (write_n)
         op_now = SBS_OP_READ;
      else
         op_now = SBS_OP_WRITE;
   end

   sbsram_burst_ctr #(
      .BW(2)
   ) u_ctr (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(!hold && load_cyc),
      .step(!hold && !load_cyc),
      .start(addr[1:0]),
      .interleave(burst_order_select),
      .addr_lsb(lsb)
   );

   // Counter supplies low bits on continue cycles
   always_comb
   begin
      if (load_cyc)
         acc_addr = addr;
      else
         acc_addr = {base_q[AW-1:2], lsb};
   end

   // Remember burst base and operation at each load
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         base_q <= '0;
         burst_op_q <= SBS_OP_IDLE;
      end
      else if (!hold && load_cyc)
      begin
         base_q <= addr;
         burst_op_q <= op_now;
      end
   end

   // Command pipeline, two stages for late write
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         op1_q <= SBS_OP_IDLE;
         op2_q <= SBS_OP_IDLE;
         a1_q <= '0;
         a2_q <= '0;
         be1_q <= '1;
         be2_q <= '1;
      end
      else if (!hold)
      begin
         op1_q <= op_now;
         a1_q <= acc_addr;
         be1_q <= any_lane_write_n;
         op2_q <= op1_q;
         a2_q <= a1_q;
         be2_q <= be1_q;
      end
   end

   // Write data is due one edge after the command in flow mode, two in pipeline
   assign wr_en = flow ? (op1_q == SBS_OP_WRITE) : (op2_q == SBS_OP_WRITE);
   assign wr_addr = flow ? a1_q : a2_q;
   assign wr_lanes_n = flow ? be1_q : be2_q;

   // Lanes left disabled keep their stored bits
   for (genvar g = 0; g < LANES; g++)
   begin : g_lane
      assign wr_word[g*LW +: LW] = wr_lanes_n[g] ? mem[wr_addr][g*LW +: LW]
         : dq_in[g*LW +: LW];
   end

   // One process owns the array; an abort with no lane enabled writes nothing
   always_ff @(posedge clk_sys)
   begin
      if (!hold && wr_en && !(&wr_lanes_n))
         mem[wr_addr] <= wr_word;
   end

   // Read output register
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end
      else if (!hold)
      begin
         rvalid_q <= (op_now == SBS_OP_READ);
         if (op_now == SBS_OP_READ)
            rdata_q <= mem[acc_addr];
      end
   end

   // Pipeline adds one more register stage
   logic [DW-1:0] pdata_q;
   logic pvalid_q;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pdata_q <= '0;
         pvalid_q <= 1'b0;
      end
      else if (!hold)
      begin
         pdata_q <= rdata_q;
         pvalid_q <= rvalid_q;
      end
   end

   // Sleep entry and exit delay counter
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sleep_cnt_q <= '0;
         asleep_q <= 1'b0;
      end
      else if (sleep_request != asleep_q)
      begin
         if (sleep_cnt_q == SLEEP_CYC - 2'h1)
         begin
            asleep_q <= sleep_request;
            sleep_cnt_q <= '0;
         end
         else
            sleep_cnt_q <= sleep_cnt_q + 2'h1;
      end
      else
         sleep_cnt_q <= '0;
   end

   assign asleep = asleep_q;

   // Data drive: output enable and sleep act without the clock
   always_comb
   begin
      if (flow)
      begin
         dq_out = rdata_q;
         dq_oe = rvalid_q;
      end
      else
      begin
         dq_out = pdata_q;
         dq_oe = pvalid_q;
      end
      if (output_enable_n || asleep_q || sleep_request)
         dq_oe = 1'b0;
      // Writes and write aborts never enable the drivers
   end

   // Sleep delay and drive checks
   a_sleep_entry: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(sleep_request) ##1 sleep_request |=> asleep_q)
      else $error("sleep not entered after two cycles");

   a_sleep_exit: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(sleep_request) ##1 !sleep_request |=> !asleep_q)
      else $error("sleep not left after two cycles");

   a_sleep_hiz: assert property (@(posedge clk_sys) disable iff (rst)
      asleep_q |-> !dq_oe)
      else $error("drive during sleep");

   // Output drive checks
   a_oe_gate: assert property (@(posedge clk_sys) disable iff (rst)
      output_enable_n |-> !dq_oe)
      else $error("drive with output enable high");

   a_pipe_lat: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && op_now == SBS_OP_READ && latency_mode_n) ##1 !hold
      ##1 (latency_mode_n && !output_enable_n && !asleep_q && !sleep_request)
      |-> dq_oe)
      else $error("pipeline read not driven");

   a_flow_lat: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && op_now == SBS_OP_READ && !latency_mode_n)
      ##1 (!latency_mode_n && !output_enable_n && !asleep_q && !sleep_request)
      |-> dq_oe)
      else $error("flow read not driven");

   a_write_hiz: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && op_now != SBS_OP_READ) ##1 !latency_mode_n |-> !dq_oe)
      else $error("driver on after write in flow mode");

   a_pipe_wr_hiz: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && op_now != SBS_OP_READ) ##1 !hold ##1 latency_mode_n |-> !dq_oe)
      else $error("driver on after write in pipeline mode");

   a_abort_hiz: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && op_now == SBS_OP_WRITE) |=> !rvalid_q)
      else $error("write marked as read data");

   // Stall and reset checks
   a_stall_keep: assert property (@(posedge clk_sys) disable iff (rst)
      hold |=> $stable(rvalid_q) && $stable(rdata_q))
      else $error("state changed during stall");

   a_stall_pipe: assert property (@(posedge clk_sys) disable iff (rst)
      hold |=> $stable(pvalid_q) && $stable(pdata_q))
      else $error("pipeline output changed during stall");

   a_stall_cmd: assert property (@(posedge clk_sys) disable iff (rst)
      hold |=> $stable(op1_q) && $stable(op2_q) && $stable(a1_q))
      else $error("command pipeline moved during stall");

   a_reset_quiet: assert property (@(posedge clk_sys)
      rst |=> !rvalid_q && !pvalid_q)
      else $error("read valid set after reset");

   // Command decode and array write checks
   a_deselect: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && load_cyc && select_first_n) |=> op1_q == SBS_OP_IDLE)
      else $error("selected with first select high");

   a_sel_second: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && load_cyc && !select_second) |=> op1_q == SBS_OP_IDLE)
      else $error("selected with second select low");

   a_read_start: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && load_cyc && selected && write_n) |=> op1_q == SBS_OP_READ && rvalid_q)
      else $error("read not started");

   a_write_start: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && load_cyc && selected && !write_n) |=> op1_q == SBS_OP_WRITE
      && a1_q == $past(addr) && be1_q == $past(any_lane_write_n))
      else $error("write not registered");

   a_lane_write: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && wr_en && !wr_lanes_n[0])
      |=> mem[$past(wr_addr)][LW-1:0] == $past(dq_in[LW-1:0]))
      else $error("enabled lane not written");

   a_abort_keep: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && wr_en && &wr_lanes_n) |=> mem[$past(wr_addr)] == $past(mem[wr_addr]))
      else $error("write abort changed the array");

   // Burst checks
   a_burst_op: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && !load_cyc) |=> op1_q == $past(burst_op_q))
      else $error("continue did not repeat operation");

   a_ctr_first: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && load_cyc) ##1 (!hold && !load_cyc) |-> lsb == (burst_order_select
      ? $past(addr[1:0]) ^ 2'h1 : $past(addr[1:0]) + 2'h1))
      else $error("first continue did not step the counter");

   a_ctr_wrap: assert property (@(posedge clk_sys) disable iff (rst)
      (!hold && load_cyc) ##1 (!hold && !load_cyc) [*4] |-> acc_addr == $past(addr, 4))
      else $error("burst did not wrap to its start");
endmodule : sbsram_core

//--- inc/sbsram_defines.svh
`ifndef SBSRAM_DEFINES_SVH
`define SBSRAM_DEFINES_SVH
// Address, data and lane widths
`define SBS_ADDR_W 10
`define SBS_LANES 4
`define SBS_LANE_W 9
// Burst counter width and wrap length
`define SBS_BURST_W 2
`define SBS_BURST_LEN 4
// Sleep entry and exit delay in clock cycles
`define SBS_SLEEP_CYC 2
// Read latency in cycles for each latency mode
`define SBS_RD_LAT_PIPE 2
`define SBS_RD_LAT_FLOW 1
`endif

//--- inc/sbsram_pkg.sv
package sbsram_pkg;
   // Operation kind carried down the pipeline
   typedef enum logic [3:0]
   {
      SBS_OP_IDLE = 4'h1,
      SBS_OP_READ = 4'h2,
      SBS_OP_WRITE = 4'h4,
      SBS_OP_NOP = 4'h8
   } sbs_op_e;
endpackage : sbsram_pkg

//--- rtl/sbsram_burst_ctr.sv
`timescale 1ns/10ps
`include "sbsram_defines.svh"
// Two-bit burst counter, linear or interleaved, wraps after four steps
module sbsram_burst_ctr
   import sbsram_pkg::*;
#(
   parameter int BW = `SBS_BURST_W
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic load,
   input wire logic step,
   input wire logic [BW-1:0] start,
   input wire logic interleave,
   output logic [BW-1:0] addr_lsb
);
   logic [BW-1:0] start_q;
   logic [BW-1:0] cnt_q;

   // Refuse widths the counter cannot serve
   if (BW != 2)
   begin : g_bad_width
      $error("Burst counter supports only two bits");
   end

   // Load start value or advance the step count
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         start_q <= '0;
         cnt_q <= '0;
      end
      else if (load)
      begin
         start_q <= start;
         cnt_q <= '0;
      end
      else if (step)
         cnt_q <= cnt_q + 2'h1;
   end

   // A continue uses the step after those already taken, so the loaded word is not repeated
   always_comb
   begin
      if (interleave)
         addr_lsb = start_q ^ (cnt_q + 2'h1);
      else
         addr_lsb = start_q + cnt_q + 2'h1;
   end
endmodule : sbsram_burst_ctr

//--- tb/sbs_ctrl_model.sv
`timescale 1ns/10ps
// Controller data side: returns write data on the edge the latency mode asks for
module sbs_ctrl_model
#(
   parameter int DW = 36
)
(
   input wire logic clk_sys,
   input wire logic clock_gate_n,
   input wire logic latency_mode_n,
   input wire logic wr_req,
   input wire logic [DW-1:0] wr_data,
   output logic [DW-1:0] dq_in
);
   logic [DW:0] s1 = '0;
   logic [DW:0] s2 = '0;
   logic [DW:0] nx;
   initial dq_in = '0;
   // Delay line moves only on edges that are not stalled
   always @(posedge clk_sys)
      if (!clock_gate_n)
      begin
         s2 = s1;
         s1 = {wr_req, wr_data};
      end
   // Data stands for one cycle, otherwise the bus toggles
   always @(negedge clk_sys)
   begin
      nx = latency_mode_n ? s2 : s1;
      dq_in <= nx[DW] ? nx[DW-1:0] : ~dq_in;
   end
endmodule : sbs_ctrl_model

//--- tb/sync_burst_sram_bus_interface_tb.sv
`timescale 1ns/10ps
`include "sbsram_defines.svh"
module sync_burst_sram_bus_interface_tb;
   localparam int LW = `SBS_LANE_W;
   localparam int DW = `SBS_LANES * LW;
   logic clk_sys = 0, rst = 1, clock_gate_n = 0, select_first_n = 1, select_second = 0;
   logic select_third_n = 1, write_n = 1, burst_step_or_load = 0, output_enable_n = 0;
   logic sleep_request = 0, latency_mode_n = 0, burst_order_select = 0, wr_req = 0;
   logic [3:0] any_lane_write_n = 4'hF;
   logic [9:0] addr = 10'h000;
   logic [DW-1:0] dq_in, dq_out, wr_data = '0;
   logic dq_oe, asleep, rd_op, wr_op, sel;
   logic [9:0] base, ea;
   logic [1:0] cnt;
   logic [DW-1:0] mem [0:1023];
   logic [DW:0] rq [2];
   logic [DW:0] e;
   logic [14:0] wq [2];
   logic [14:0] w;
   int fails = 0, num_checks = 0, cyc = 0;

   sbsram_core DUT
   (
      .clk_sys, .rst, .clock_gate_n, .select_first_n, .select_second, .select_third_n,
      .write_n, .any_lane_write_n, .burst_step_or_load, .output_enable_n, .sleep_request,
      .latency_mode_n, .burst_order_select, .addr, .dq_in, .dq_out, .dq_oe, .asleep
   );
   sbs_ctrl_model #(.DW(DW)) ctrl
   (
      .clk_sys, .clock_gate_n, .latency_mode_n, .wr_req, .wr_data, .dq_in
   );

   always #5 clk_sys = ~clk_sys;

   // Compare and count
   task automatic chk(input logic [DW-1:0] exp, input logic [DW-1:0] got);
      num_checks++;
      if (exp !== got)
      begin
         fails++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk

   // One command cycle, inputs change after the falling edge
   task automatic cmd(input logic ld_n, input logic [2:0] s, input logic wn,
      input logic [3:0] ln, input logic [9:0] a, input logic [DW-1:0] d);
      @(negedge clk_sys);
      clock_gate_n <= 1'h0;
      burst_step_or_load <= ld_n;
      {select_first_n, select_second, select_third_n} <= s;
      write_n <= wn;
      wr_req <= !wn;
      any_lane_write_n <= ln;
      addr <= a;
      wr_data <= d;
   endtask : cmd

   // Deselected load cycles
   task automatic idle(input int n);
      repeat (n) cmd(1'h0, 3'h4, 1'h1, 4'hF, 10'h000, '0);
   endtask : idle

   // Ignored edges
   task automatic stall(input int n);
      repeat (n)
      begin
         @(negedge clk_sys);
         clock_gate_n <= 1'h1;
      end
   endtask : stall

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   // Reference: decode taken edges, track burst address and pending traffic
   always @(posedge clk_sys)
      if (rst)
      begin
         {rd_op, wr_op, base, cnt} = '0;
         rq = '{default: '0};
         wq = '{default: '0};
      end
      else if (!clock_gate_n)
      begin
         w = latency_mode_n ? wq[1] : wq[0];
         for (int i = 0; i < 4; i++)
            if (w[14] && !w[10+i])
               mem[w[9:0]][i*LW +: LW] = dq_in[i*LW +: LW];
         sel = !select_first_n && select_second && !select_third_n;
         if (!burst_step_or_load)
         begin
            rd_op = sel && write_n;
            wr_op = sel && !write_n;
            base = addr;
            cnt = 2'h0;
         end
         else
            cnt = cnt + 2'h1;
         ea = {base[9:2], burst_order_select ? base[1:0] ^ cnt : base[1:0] + cnt};
         rq[1] = rq[0];
         rq[0] = {rd_op, mem[ea]};
         wq[1] = wq[0];
         wq[0] = {wr_op, any_lane_write_n, ea};
      end

   // Data pins against the expected read pipeline
   always @(negedge clk_sys)
      if (!rst)
      begin
         e = latency_mode_n ? rq[1] : rq[0];
         chk(e[DW] && !output_enable_n, dq_oe);
         if (e[DW] && !output_enable_n)
            chk(e[DW-1:0], dq_out);
      end

   // Hang guard
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         fails++;
         final_report();
      end
   end

   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(1'h0, dq_oe);
      rst <= 1'h0;
      for (int m = 0; m < 2; m++)
      begin
         latency_mode_n <= m[0];
         burst_order_select <= m[0];
         idle(3);
         cmd(1'h0, 3'h2, 1'h0, 4'h0, 10'h010, 36'h1_2345_6789 + m);
         cmd(1'h0, 3'h2, 1'h0, 4'hA, 10'h010, 36'hA_BCDE_F012);
         cmd(1'h0, 3'h2, 1'h0, 4'hF, 10'h010, 36'hF_FFFF_FFFF);
         idle(3);
         cmd(1'h0, 3'h2, 1'h1, 4'h0, 10'h010, '0);
         cmd(1'h0, 3'h2, 1'h0, 4'h0, 10'h011, 36'h3_0F0F_0F0F + m);
         stall(3);
         idle(3);
         cmd(1'h0, 3'h2, 1'h1, 4'h0, 10'h011, '0);
         for (int k = 0; k < 3; k++)
            cmd(1'h0, 3'h2 ^ (3'h1 << k), 1'h1, 4'h0, 10'h010, '0);
         output_enable_n <= 1'h1;
         cmd(1'h0, 3'h2, 1'h1, 4'h0, 10'h010, '0);
         idle(3);
         output_enable_n <= 1'h0;
         for (int k = 0; k < 4; k++)
            cmd(k != 0, k ? 3'h5 : 3'h2, 1'h0, 4'h0, 10'h022, 36'h5_A5A5_0000 + 16*k + m);
         idle(3);
         for (int k = 0; k < 5; k++)
            cmd(k != 0, k ? 3'h5 : 3'h2, k == 0, 4'hF, 10'h022, '0);
         idle(3);
         cmd(1'h1, 3'h4, 1'h1, 4'hF, 10'h000, '0);
         idle(3);
         $display("test mode %0d done", m);
      end
      sleep_request <= 1'h1;
      @(negedge clk_sys);
      chk(1'h0, asleep);
      @(negedge clk_sys);
      chk(1'h1, asleep);
      sleep_request <= 1'h0;
      @(negedge clk_sys);
      chk(1'h1, asleep);
      @(negedge clk_sys);
      chk(1'h0, asleep);
      $display("test sleep done");
      final_report();
   end
endmodule : sync_burst_sram_bus_interface_tb
